/* File: core/adc_readout_pkg.sv */
// Purpose: Shared constants and types of the sampling converter serial readout
// Assumes: Link edges are counted from the fall of the select line
// Notes:   Edge numbers are falling edges of the transfer clock, the first being 1
package adc_readout_pkg;

    localparam int RESULT_BITS     = 12;
    localparam int BIT_IDX_W       = $clog2(RESULT_BITS);
    localparam int CONV_CYCLES     = 12;
    localparam int EDGE_CNT_W      = 5;

    // Falling edge that turns the output driver on and carries the null bit
    localparam logic [EDGE_CNT_W-1:0] EDGE_NULL      = 5'h02;
    localparam logic [EDGE_CNT_W-1:0] EDGE_CONV_LAST = EDGE_CNT_W'(int'(EDGE_NULL) + CONV_CYCLES);
    localparam logic [EDGE_CNT_W-1:0] EDGE_LSB_LAST  = EDGE_CNT_W'(int'(EDGE_CONV_LAST) + RESULT_BITS - 1);
    localparam logic [EDGE_CNT_W-1:0] EDGE_ZERO      = EDGE_CNT_W'(int'(EDGE_LSB_LAST) + 1);
    localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST   = 5'h00;

    // Sample window in half cycles of the transfer clock
    localparam int SAMPLE_MIN_HALF = 3;
    localparam int SAMPLE_MAX_HALF = 4;

    // Frame rate observer on the system clock
    localparam int CLK_PERIOD_NS     = 25;
    localparam int MAX_RATE_HZ       = 20000;
    localparam int MIN_FRAME_NS      = 1000000000 / MAX_RATE_HZ;
    localparam int MIN_FRAME_CYCLES  = (MIN_FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W             = $clog2(MIN_FRAME_CYCLES + 1);

    typedef enum logic [3:0]
    {
        LK_SAMPLE  = 4'h1,
        LK_CONVERT = 4'h2,
        LK_TRAIL   = 4'h4,
        LK_ZERO    = 4'h8
    } link_state_t;

    typedef enum logic [2:0]
    {
        ST_EMPTY   = 3'h1,
        ST_FULL    = 3'h2,
        ST_RELEASE = 3'h4
    } stage_state_t;

endpackage

/* File: core/result_stream_if.sv */
// Purpose: Valid/ready word stream between the readout and its result buffer
// Assumes: A word moves on a clock edge where valid and ready are both high
// Notes:   Data must stay stable while valid is high and ready low
`timescale 1ns/100ps
interface result_stream_if
#(
    parameter int WIDTH = 12
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source
    (
        output valid,
        output data,
        input  ready
    );

    modport sink
    (
        input  valid,
        input  data,
        output ready
    );
endinterface

/* File: core/level_sync.sv */
// Purpose: Two-flop synchroniser for levels entering a clock domain
// Assumes: Each bit is a slow level or one half of a four-phase handshake
// Notes:   The first stage feeds only the second
`timescale 1ns/100ps
module level_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] din,
    output      logic [WIDTH-1:0] dout
);
    typedef struct packed
    {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_t;

    sync_t syncR;
    sync_t syncNxt;

    always_comb
    begin
        syncNxt.stage1 = din;
        syncNxt.stage2 = syncR.stage1;
    end

    always_ff @(posedge clk)
    begin
        syncR <= syncNxt;
    end

    assign dout = syncR.stage2;
endmodule

/* File: core/result_buffer.sv */
// Purpose: Two-entry result buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two, at least two
// Notes:   Fill side stalls through ready when both entries hold words
`timescale 1ns/100ps
module result_buffer
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
)
(
    input  wire logic       clk,
    input  wire logic       nrst,
    result_stream_if.sink   fill,
    result_stream_if.source drain
);
    localparam int PTR_W = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : gDepthCheck
            $error("result_buffer depth must be a power of two, at least two");
        end
    endgenerate

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wrPtr;
        logic [PTR_W-1:0]            rdPtr;
        logic [PTR_W:0]              count;
    } buf_t;

    buf_t bufR;
    buf_t bufNxt;
    logic push;
    logic pop;

    assign fill.ready  = (bufR.count != (PTR_W+1)'(DEPTH));
    assign drain.valid = (bufR.count != '0);
    assign drain.data  = bufR.mem[bufR.rdPtr];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    always_comb
    begin
        bufNxt = bufR;
        if (push)
        begin
            bufNxt.mem[bufR.wrPtr] = fill.data;
            bufNxt.wrPtr           = bufR.wrPtr + 1'b1;
        end
        if (pop)
        begin
            bufNxt.rdPtr = bufR.rdPtr + 1'b1;
        end
        if (push && !pop)
        begin
            bufNxt.count = bufR.count + 1'b1;
        end
        else if (pop && !push)
        begin
            bufNxt.count = bufR.count - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            bufR <= '0;
        end
        else
        begin
            bufR <= bufNxt;
        end
    end
endmodule

/* File: core/sampling_adc_serial_readout.sv */
// Purpose: Serial readout and sequencing of a 12-bit sampling converter
// Assumes: Host drives select_shutdown_n and transfer_clock; results arrive on clk
// Notes:   Link logic runs on falling transfer_clock edges, cleared while select is high
//
// What this block does
// RQ1: Select low means active; select high means full shutdown.
// RQ2: Falling select starts a new sample and readout exchange.
// RQ3: Output stays high impedance until the second transfer clock pulse after select falls.
// RQ4: Output gives one null bit, then the result over the next twelve edges.
// RQ5: Each conversion yields twelve data bits in straight binary.
// RQ6: Output bits change on falling clock edges; host captures on rising edges.
// RQ7: Input is sampled for 1.5 to 2.0 clock cycles before conversion.
// RQ8: Conversion takes twelve transfer clock cycles.
// RQ9: Host starts conversions no faster than 20 kHz on average.
// RQ10: Raising select resets the transfer sequence for a clean next exchange.
// RQ11: Bias, comparator and reference power down when conversion ends.
// RQ12: With clock running after conversion, result repeats LSB first, then zeroes.
// RQ13: Host keeps select low only as long as the transfer needs.
// RQ14: First result copy goes out most significant bit first.
`timescale 1ns/100ps
module sampling_adc_serial_readout
#(
    parameter int BUF_DEPTH = 2
)
(
    input  wire logic                                  clk,
    input  wire logic                                  nrst,
    input  wire logic                                  transfer_clock,
    input  wire logic                                  select_shutdown_n,
    input  wire logic [adc_readout_pkg::RESULT_BITS-1:0] resultData,
    input  wire logic                                  resultValid,
    output      logic                                  resultReady,
    output      logic                                  serialOut,
    output      logic                                  serialOutEn,
    output      logic                                  sampleActive,
    output      logic                                  converting,
    output      logic                                  biasEnable,
    output      logic                                  referenceConnect,
    output      logic                                  hostSelected,
    output      logic                                  wordTaken,
    output      logic                                  rateFault
);
    import adc_readout_pkg::*;

    typedef struct packed
    {
        link_state_t           state;
        logic [EDGE_CNT_W-1:0] edgeCnt;
        logic [RESULT_BITS-1:0] word;
        logic                  taken;
        logic                  outEn;
        logic                  outBit;
        logic                  sampling;
        logic                  converting;
        logic                  biasOn;
    } link_t;

    typedef struct packed
    {
        stage_state_t           state;
        logic [RESULT_BITS-1:0] word;
        logic                   selPrev;
        logic                   takenPrev;
        logic                   takenPulse;
        logic [GAP_W-1:0]       gapCnt;
        logic                   rateFault;
    } core_t;

    localparam link_t LINK_RST = '{
        state:      LK_SAMPLE,
        edgeCnt:    EDGE_CNT_RST,
        word:       '0,
        taken:      1'b0,
        outEn:      1'b0,
        outBit:     1'b0,
        sampling:   1'b1,
        converting: 1'b0,
        biasOn:     1'b1
    };

    localparam core_t CORE_RST = '{
        state:      ST_EMPTY,
        word:       '0,
        selPrev:    1'b1,
        takenPrev:  1'b0,
        takenPulse: 1'b0,
        gapCnt:     GAP_W'(MIN_FRAME_CYCLES),
        rateFault:  1'b0
    };

    link_t                 lk;
    link_t                 lkNxt;
    core_t                 cr;
    core_t                 crNxt;
    logic                  validSync;
    logic [1:0]            coreSync;
    logic                  selSync;
    logic                  takenSync;
    logic [BIT_IDX_W-1:0]  msbIdx;
    logic [BIT_IDX_W-1:0]  lsbIdx;

    result_stream_if #(.WIDTH(RESULT_BITS)) inStream ();
    result_stream_if #(.WIDTH(RESULT_BITS)) outStream ();

    assign inStream.valid = resultValid;
    assign inStream.data  = resultData;
    assign resultReady    = inStream.ready;

    result_buffer #(
        .WIDTH (RESULT_BITS),
        .DEPTH (BUF_DEPTH)
    ) uBuffer (
        .clk   (clk),
        .nrst  (nrst),
        .fill  (inStream.sink),
        .drain (outStream.source)
    );

    // System clock side: stage one word for the link, four-phase handshake

    level_sync #(.WIDTH(2)) uCoreSync (
        .clk  (clk),
        .din  ({select_shutdown_n, lk.taken}),
        .dout (coreSync)
    );

    assign selSync         = coreSync[1];
    assign takenSync       = coreSync[0];
    assign outStream.ready = (cr.state == ST_EMPTY);

    always_comb
    begin
        crNxt            = cr;
        crNxt.selPrev    = selSync;
        crNxt.takenPrev  = takenSync;
        crNxt.takenPulse = takenSync && !cr.takenPrev;
        case (cr.state)
            ST_EMPTY:
            begin
                if (outStream.valid)
                begin
                    crNxt.word  = outStream.data;
                    crNxt.state = ST_FULL;
                end
            end
            ST_FULL:
            begin
                if (takenSync)
                begin
                    crNxt.state = ST_RELEASE;
                end
            end
            ST_RELEASE:
            begin
                // Next word waits until the frame that took this one has ended
                if (!takenSync)
                begin
                    crNxt.state = ST_EMPTY; // RQ10
                end
            end
            default:
            begin
                crNxt.state = ST_EMPTY;
            end
        endcase
        // Flags frames that start closer together than the host may allow
        if (cr.selPrev && !selSync)
        begin
            if (cr.gapCnt < GAP_W'(MIN_FRAME_CYCLES))
            begin
                crNxt.rateFault = 1'b1; // RQ9
            end
            crNxt.gapCnt = '0;
        end
        else if (cr.gapCnt != GAP_W'(MIN_FRAME_CYCLES))
        begin
            crNxt.gapCnt = cr.gapCnt + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cr <= CORE_RST;
        end
        else
        begin
            cr <= crNxt;
        end
    end

    assign hostSelected = !cr.selPrev;
    assign wordTaken    = cr.takenPulse;
    assign rateFault    = cr.rateFault;

    // Link side: falling-edge sequencer, held clear while select is high

    level_sync #(.WIDTH(1)) uLinkSync (
        .clk  (transfer_clock),
        .din  (cr.state == ST_FULL),
        .dout (validSync)
    );

    assign msbIdx = BIT_IDX_W'(EDGE_CONV_LAST - 1'b1 - lk.edgeCnt);
    assign lsbIdx = BIT_IDX_W'(lk.edgeCnt - (EDGE_CONV_LAST - 1'b1));

    always_comb
    begin
        lkNxt = lk;
        if (lk.edgeCnt != EDGE_ZERO)
        begin
            lkNxt.edgeCnt = lk.edgeCnt + 1'b1;
        end
        case (lk.state)
            LK_SAMPLE:
            begin
                // Second falling edge ends sampling, starts conversion, sends null bit
                if (lk.edgeCnt == EDGE_NULL - 1'b1)
                begin
                    lkNxt.state      = LK_CONVERT;
                    lkNxt.sampling   = 1'b0; // RQ7
                    lkNxt.converting = 1'b1;
                    lkNxt.outEn      = 1'b1; // RQ3
                    lkNxt.outBit     = 1'b0; // RQ4
                    lkNxt.word       = validSync ? cr.word : '0; // RQ5
                    lkNxt.taken      = validSync;
                end
            end
            LK_CONVERT:
            begin
                lkNxt.outBit = lk.word[msbIdx]; // RQ14
                if (lk.edgeCnt == EDGE_CONV_LAST - 1'b1)
                begin
                    lkNxt.state      = LK_TRAIL; // RQ8
                    lkNxt.converting = 1'b0;
                    lkNxt.biasOn     = 1'b0; // RQ11
                end
            end
            LK_TRAIL:
            begin
                lkNxt.outBit = lk.word[lsbIdx]; // RQ12
                if (lk.edgeCnt == EDGE_LSB_LAST - 1'b1)
                begin
                    lkNxt.state = LK_ZERO;
                end
            end
            LK_ZERO:
            begin
                lkNxt.outBit = 1'b0; // RQ12
            end
            default:
            begin
                lkNxt = LINK_RST;
            end
        endcase
    end

    // Output changes on falling edges only; select high clears the sequence
    always_ff @(negedge transfer_clock or posedge select_shutdown_n) // RQ6
    begin
        if (select_shutdown_n)
        begin
            lk <= LINK_RST; // RQ10
        end
        else
        begin
            lk <= lkNxt; // RQ2
        end
    end

    assign serialOut        = lk.outBit;
    assign serialOutEn      = lk.outEn;
    assign sampleActive     = lk.sampling && !select_shutdown_n; // RQ1
    assign converting       = lk.converting;
    assign biasEnable       = lk.biasOn && !select_shutdown_n; // RQ1
    assign referenceConnect = lk.biasOn && !select_shutdown_n; // RQ11

    // Checks on the link sequence and the system clock word stage

    sequence s_sampling;
        lk.sampling ##1 lk.sampling ##1 !lk.sampling;
    endsequence

    sequence s_conv;
        lk.converting [*6] ##1 lk.converting [*6];
    endsequence

    AST_HIZ_EARLY: assert property ( // RQ3
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt < EDGE_NULL) |-> !lk.outEn)
        else $error("output driver enabled before the second clock pulse");

    AST_NULL_BIT: assert property ( // RQ4
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt == EDGE_NULL - 1'b1) |=> (lk.outEn && !lk.outBit))
        else $error("null bit missing when output enables");

    AST_MSB_FIRST: assert property ( // RQ14
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt == EDGE_NULL) |=> (lk.outBit == lk.word[RESULT_BITS-1]))
        else $error("first data bit is not the most significant");

    AST_MSB_LAST: assert property ( // RQ4
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt == EDGE_CONV_LAST - 1'b1) |=> (lk.outBit == lk.word[0]))
        else $error("twelfth data bit is not the least significant");

    AST_SAMPLE_WINDOW: assert property ( // RQ7
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt == EDGE_CNT_RST) |-> s_sampling)
        else $error("sample window not ended on the second falling edge");

    AST_CONV_LENGTH: assert property ( // RQ8
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt == EDGE_NULL) |-> s_conv ##1 !lk.converting)
        else $error("conversion does not last twelve clock cycles");

    AST_POWER_DOWN: assert property ( // RQ11
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt >= EDGE_CONV_LAST) |-> (!lk.biasOn && !lk.converting))
        else $error("bias still on after conversion end");

    AST_LSB_REPEAT: assert property ( // RQ12
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt == EDGE_LSB_LAST - 1'b1) |=> (lk.outBit == lk.word[RESULT_BITS-1]))
        else $error("least significant first repeat ends on the wrong bit");

    AST_ZERO_TAIL: assert property ( // RQ12
        @(negedge transfer_clock) disable iff (select_shutdown_n)
        (lk.edgeCnt == EDGE_ZERO) |-> !lk.outBit)
        else $error("tail after the repeat is not zero");

    AST_STAGE_STABLE: assert property ( // RQ5
        @(posedge clk) disable iff (!nrst)
        (cr.state == ST_FULL) |=> $stable(cr.word))
        else $error("staged word changed while offered to the link");

    AST_RELEASE_WAIT: assert property ( // RQ10
        @(posedge clk) disable iff (!nrst)
        (cr.state == ST_RELEASE && takenSync) |=> (cr.state == ST_RELEASE))
        else $error("new word staged before the taking frame ended");

    // Link may only take a word that the stage really offered
    AST_TAKE_FROM_FULL: assert property ( // RQ5
        @(posedge clk) disable iff (!nrst)
        takenSync |-> (cr.state != ST_EMPTY))
        else $error("link took a word while the stage was empty");
endmodule

/* File: verif/adc_host_model.sv */
// Purpose: Host side of the converter link: select line, transfer clock, bit capture
// Assumes: Transfer clock idles low and stands still between frames
// Notes:   snap[j] is taken at the rising edge that follows falling edge j
`timescale 1ns/100ps
module adc_host_model
#(
    parameter real HALF = 62.5
)
(
    output      logic       transfer_clock,
    output      logic       select_shutdown_n,
    input  wire logic [4:0] status
);
    logic [4:0] snap [0:31];

    initial
    begin
        transfer_clock    = 1'b0;
        select_shutdown_n = 1'b1;
    end

    task automatic frame(input int n);
        select_shutdown_n = 1'b0;
        for (int j = 0; j <= n; j++)
        begin
            #(HALF);
            transfer_clock = 1'b1;
            snap[j] = status;
            #(HALF);
            if (j < n)
                transfer_clock = 1'b0;
        end
        // Select goes high before the clock falls, so no extra edge is counted
        select_shutdown_n = 1'b1;
        #(HALF);
        transfer_clock = 1'b0;
    endtask
endmodule

/* File: verif/sampling_adc_serial_readout_tb_top.sv */
// Purpose: Self-checking bench of the converter serial readout
// Assumes: Host model owns select and transfer clock; bench feeds result words
// Notes:   Frames are spaced beyond the minimum start interval except in the rate case
`timescale 1ns/100ps
module sampling_adc_serial_readout_tb_top;
    import adc_readout_pkg::*;

    logic        clk;
    logic        nrst;
    logic        transfer_clock;
    logic        select_shutdown_n;
    logic [11:0] resultData;
    logic        resultValid;
    logic        resultReady;
    logic        serialOut;
    logic        serialOutEn;
    logic        sampleActive;
    logic        converting;
    logic        biasEnable;
    logic        referenceConnect;
    logic        hostSelected;
    logic        wordTaken;
    logic        rateFault;
    logic [4:0]  status;
    int          failures = 0;
    int          checked = 0;
    int          taken = 0;

    assign status = {sampleActive, biasEnable, converting, serialOutEn, serialOut};

    sampling_adc_serial_readout #(.BUF_DEPTH(2)) u_dut
    (
        .clk               (clk),
        .nrst              (nrst),
        .transfer_clock    (transfer_clock),
        .select_shutdown_n (select_shutdown_n),
        .resultData        (resultData),
        .resultValid       (resultValid),
        .resultReady       (resultReady),
        .serialOut         (serialOut),
        .serialOutEn       (serialOutEn),
        .sampleActive      (sampleActive),
        .converting        (converting),
        .biasEnable        (biasEnable),
        .referenceConnect  (referenceConnect),
        .hostSelected      (hostSelected),
        .wordTaken         (wordTaken),
        .rateFault         (rateFault)
    );

    adc_host_model u_host
    (
        .transfer_clock    (transfer_clock),
        .select_shutdown_n (select_shutdown_n),
        .status            (status)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
        if (wordTaken === 1'b1)
            taken <= taken + 1;

    task automatic end_sim;
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Expected {sampleActive, biasEnable, converting, serialOutEn, serialOut} after fall j
    function automatic logic [4:0] exp_snap(input logic [11:0] w, input int j);
        logic b;
        b = (j >= 3 && j <= 14) ? w[14-j] : ((j >= 15 && j <= 25) ? w[j-14] : 1'b0);
        return {j < 2, j < 14, j >= 2 && j < 14, j >= 2, b};
    endfunction

    task automatic push(input logic [11:0] w, input bit expTaken);
        int i;
        @(negedge clk);
        resultData  = w;
        resultValid = 1'b1;
        for (i = 0; i < 8 && resultReady !== 1'b1; i++)
            @(negedge clk);
        check(16'(i < 8), 16'(expTaken));
        if (i == 8 && expTaken)
            end_sim();
        @(negedge clk);
        resultValid = 1'b0;
    endtask

    task automatic run(input logic [11:0] w, input int n, input bit hasWord);
        int t0;
        logic [4:0] e;
        t0 = taken;
        #3;
        fork
            u_host.frame(n);
            begin
                repeat (6) @(negedge clk);
                check(16'({hostSelected, referenceConnect}), 16'h0003);
            end
        join
        for (int j = 0; j <= n; j++)
        begin
            e = exp_snap(w, j);
            check(16'(u_host.snap[j] & {4'hF, e[1]}), 16'(e));
        end
        repeat (8) @(negedge clk);
        check(16'(taken - t0), 16'(hasWord));
        check(16'(status[4:1]), 16'h0000);
        check(16'({referenceConnect, hostSelected}), 16'h0000);
        repeat (2100) @(negedge clk);
    endtask

    task automatic sc_reset;
        check(16'({resultReady, rateFault, wordTaken, serialOutEn}), 16'h0008);
        check(16'({biasEnable, referenceConnect, sampleActive, hostSelected}), 16'h0000);
    endtask

    task automatic sc_stream;
        push(12'hFFF, 1'b1);
        push(12'h001, 1'b1);
        push(12'hA5C, 1'b1);
        push(12'h3A6, 1'b0);
        run(12'hFFF, 28, 1'b1);
        push(12'h3A6, 1'b1);
        run(12'h001, 28, 1'b1);
        run(12'hA5C, 28, 1'b1);
        run(12'h3A6, 28, 1'b1);
    endtask

    task automatic sc_abort_empty;
        run(12'h000, 8, 1'b0);
        run(12'h000, 28, 1'b0);
    endtask

    task automatic sc_rate;
        check(16'(rateFault), 16'h0000);
        #3;
        u_host.frame(3);
        repeat (20) @(negedge clk);
        u_host.frame(3);
        repeat (10) @(negedge clk);
        check(16'(rateFault), 16'h0001);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check(16'(rateFault), 16'h0000);
    endtask

    initial
    begin
        nrst        = 1'b0;
        resultValid = 1'b0;
        resultData  = 12'h000;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        sc_reset();
        sc_stream();
        sc_abort_empty();
        sc_rate();
        end_sim();
    end

    initial
    begin
        #2000000;
        failures++;
        end_sim();
    end
endmodule
